// ===== src/spinv_pkg.sv
package spinv_pkg;

    // =========================================================
    // Geometry and rates
    localparam int ADDR_W = 18;
    localparam int MEM_DEPTH = 262144;
    localparam logic [1:0] ADDR_BYTES_LAST = 2'h2;
    localparam int CORE_CLK_HZ = 25000000;
    // Fastest serial clock the pins allow; sampling here needs far less
    localparam int SCK_MAX_HZ = 33000000;

    // =========================================================
    // Command codes
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_READ_ID = 8'h9f;

    // =========================================================
    // Status byte layout and reset values
    localparam int SR_WEL_BIT = 1;
    localparam int SR_BP_LSB = 2;
    localparam int SR_PPE_BIT = 7;
    localparam logic WEL_RESET = 1'b0;
    localparam logic PPE_RESET = 1'b0;
    localparam logic [1:0] BP_RESET = 2'h0;

    // =========================================================
    // Block protection
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [17:0] QUARTER_BASE = 18'h30000;
    localparam logic [17:0] HALF_BASE = 18'h20000;

    typedef enum logic [3:0] {
        ST_CMD = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_DUMMY = 4'b0010,
        ST_RDATA = 4'b0011,
        ST_WDATA = 4'b0100,
        ST_WSR = 4'b0101,
        ST_STAT = 4'b0110,
        ST_ID = 4'b0111,
        ST_IGNORE = 4'b1000
    } spinv_state_type;

    function automatic logic spinv_blocked(input logic [1:0] bp, input logic [17:0] a);
        spinv_blocked = (bp == BP_ALL) || (bp == BP_HALF && a >= HALF_BASE)
            || (bp == BP_QUARTER && a >= QUARTER_BASE);
    endfunction : spinv_blocked

    function automatic logic spinv_is_mem_op(input logic [7:0] op);
        spinv_is_mem_op = (op == OP_READ) || (op == OP_FAST_READ) || (op == OP_WRITE);
    endfunction : spinv_is_mem_op

endpackage : spinv_pkg

// ===== src/spinv_ifs.sv
`timescale 1ns/1ps
`default_nettype none

interface spinv_pin_if;
    logic sel;
    logic sel_start;
    logic sck_rise;
    logic sck_fall;
    logic si;
    logic wp_n;
    modport src (output sel, sel_start, sck_rise, sck_fall, si, wp_n);
    modport dst (input sel, sel_start, sck_rise, sck_fall, si, wp_n);
endinterface : spinv_pin_if

interface spinv_mem_if;
    logic [17:0] addr;
    logic [7:0] wdata;
    logic we;
    logic [7:0] rdata;
    modport user (output addr, wdata, we, input rdata);
    modport store (input addr, wdata, we, output rdata);
endinterface : spinv_mem_if

`default_nettype wire

// ===== src/spinv_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module spinv_pin_sync (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    spinv_pin_if.src pin
);
    // =========================================================
    // Two-stage synchronisers, third stage for edges
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic sck_d_reg;
    logic sel_d_reg;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta_reg <= 4'hf;
            sync_reg <= 4'hf;
            sck_d_reg <= 1'b0;
            sel_d_reg <= 1'b0;
        end else begin
            meta_reg <= {wp_n, si, sck, cs_n};
            sync_reg <= meta_reg;
            sck_d_reg <= sync_reg[1];
            sel_d_reg <= ~sync_reg[0];
        end
    end

    // Clock edges reach the core only while selected
    assign pin.sel = ~sync_reg[0];
    assign pin.sel_start = ~sync_reg[0] & ~sel_d_reg;
    assign pin.sck_rise = ~sync_reg[0] & sync_reg[1] & ~sck_d_reg;
    assign pin.sck_fall = ~sync_reg[0] & ~sync_reg[1] & sck_d_reg;
    assign pin.si = sync_reg[2];
    assign pin.wp_n = sync_reg[3];

endmodule : spinv_pin_sync

`default_nettype wire

// ===== src/spinv_mem.sv
`timescale 1ns/1ps
`default_nettype none

module spinv_mem (
    input wire logic core_clk,
    spinv_mem_if.store mem
);
    // =========================================================
    // Byte array, registered read
    logic [7:0] cell_mem [spinv_pkg::MEM_DEPTH];
    logic [7:0] rdata_reg;

    always_ff @(posedge core_clk) begin
        if (mem.we) begin
            cell_mem[mem.addr] <= mem.wdata;
        end
        rdata_reg <= cell_mem[mem.addr];
    end

    assign mem.rdata = rdata_reg;

endmodule : spinv_mem

`default_nettype wire

// ===== src/spinv_port.sv
`timescale 1ns/1ps
`default_nettype none

module spinv_port #(
    // Arbitrary identification value: maker, density, revision, spare
    parameter logic [31:0] ID_VALUE = 32'h5a_12_01_00
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    output logic standby
);
    // =========================================================
    // Pin front end and storage
    spinv_pin_if pin ();
    spinv_mem_if mem ();

    spinv_pin_sync u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .cs_n(cs_n),
        .sck(sck),
        .si(si),
        .wp_n(wp_n),
        .pin(pin.src)
    );

    spinv_mem u_mem (
        .core_clk(core_clk),
        .mem(mem.store)
    );

    // =========================================================
    // State
    spinv_pkg::spinv_state_type state_reg, state_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] rx_reg, rx_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [17:0] addr_reg, addr_next;
    logic [1:0] addr_cnt_reg, addr_cnt_next;
    logic [1:0] id_idx_reg, id_idx_next;
    logic wel_reg, wel_next;
    logic ppe_reg, ppe_next;
    logic [1:0] bp_reg, bp_next;
    logic clr_wel_reg, clr_wel_next;
    logic [7:0] tx_reg, tx_next;
    logic so_reg, so_next;
    logic so_oe_reg, so_oe_next;
    logic standby_reg;
    logic we_reg, we_next;
    logic [7:0] wdata_reg, wdata_next;
    logic [7:0] status_word;

    // =========================================================
    // Decoding
    wire [7:0] rx_shift = {rx_reg[6:0], pin.si};
    wire byte_done = pin.sck_rise && (bit_cnt_reg == 3'h7);
    wire out_phase = (state_reg == spinv_pkg::ST_RDATA) || (state_reg == spinv_pkg::ST_STAT)
        || (state_reg == spinv_pkg::ST_ID);
    wire status_locked = !pin.wp_n && ppe_reg;
    wire addr_blocked = spinv_pkg::spinv_blocked(bp_reg, addr_reg);
    wire [17:0] addr_shift = {addr_reg[9:0], rx_shift};
    wire [31:0] id_shift = ID_VALUE << {id_idx_reg, 3'h0};
    wire [7:0] out_byte = (state_reg == spinv_pkg::ST_STAT) ? status_word
        : (state_reg == spinv_pkg::ST_ID) ? id_shift[31:24] : mem.rdata;
    wire cmd_is_mem = spinv_pkg::spinv_is_mem_op(rx_shift);

    always_comb begin
        status_word = 8'h00;
        status_word[spinv_pkg::SR_WEL_BIT] = wel_reg;
        status_word[spinv_pkg::SR_BP_LSB +: 2] = bp_reg;
        status_word[spinv_pkg::SR_PPE_BIT] = ppe_reg;
    end

    // =========================================================
    // Command sequencer
    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        rx_next = rx_reg;
        cmd_next = cmd_reg;
        addr_next = addr_reg;
        addr_cnt_next = addr_cnt_reg;
        id_idx_next = id_idx_reg;
        wel_next = wel_reg;
        ppe_next = ppe_reg;
        bp_next = bp_reg;
        clr_wel_next = clr_wel_reg;
        tx_next = tx_reg;
        so_next = so_reg;
        so_oe_next = so_oe_reg;
        we_next = 1'b0;
        wdata_next = wdata_reg;
        if (we_reg) begin
            addr_next = addr_reg + 18'h1;
        end
        if (!pin.sel || pin.sel_start) begin
            state_next = spinv_pkg::ST_CMD;
            bit_cnt_next = 3'h0;
            so_oe_next = 1'b0;
            if (clr_wel_reg) begin
                wel_next = 1'b0;
            end
            clr_wel_next = 1'b0;
        end else begin
            if (pin.sck_rise && state_reg != spinv_pkg::ST_IGNORE) begin
                rx_next = rx_shift;
                bit_cnt_next = bit_cnt_reg + 3'h1;
            end
            if (byte_done) begin
                case (state_reg)
                    spinv_pkg::ST_CMD: begin
                        cmd_next = rx_shift;
                        addr_cnt_next = 2'h0;
                        id_idx_next = 2'h0;
                        state_next = spinv_pkg::ST_IGNORE;
                        if (cmd_is_mem) begin
                            state_next = spinv_pkg::ST_ADDR;
                        end else if (rx_shift == spinv_pkg::OP_READ_STATUS) begin
                            state_next = spinv_pkg::ST_STAT;
                        end else if (rx_shift == spinv_pkg::OP_WRITE_STATUS) begin
                            state_next = spinv_pkg::ST_WSR;
                        end else if (rx_shift == spinv_pkg::OP_READ_ID) begin
                            state_next = spinv_pkg::ST_ID;
                        end else if (rx_shift == spinv_pkg::OP_WRITE_ENABLE) begin
                            wel_next = 1'b1;
                        end else if (rx_shift == spinv_pkg::OP_WRITE_DISABLE) begin
                            wel_next = 1'b0;
                        end
                        if (rx_shift == spinv_pkg::OP_WRITE
                                || rx_shift == spinv_pkg::OP_WRITE_STATUS) begin
                            clr_wel_next = 1'b1;
                        end
                    end
                    spinv_pkg::ST_ADDR: begin
                        addr_next = addr_shift;
                        addr_cnt_next = addr_cnt_reg + 2'h1;
                        if (addr_cnt_reg == spinv_pkg::ADDR_BYTES_LAST) begin
                            if (cmd_reg == spinv_pkg::OP_WRITE) begin
                                state_next = spinv_pkg::ST_WDATA;
                            end else if (cmd_reg == spinv_pkg::OP_FAST_READ) begin
                                state_next = spinv_pkg::ST_DUMMY;
                            end else begin
                                state_next = spinv_pkg::ST_RDATA;
                            end
                        end
                    end
                    spinv_pkg::ST_DUMMY: begin
                        state_next = spinv_pkg::ST_RDATA;
                    end
                    spinv_pkg::ST_RDATA: begin
                        addr_next = addr_reg + 18'h1;
                    end
                    spinv_pkg::ST_WDATA: begin
                        wdata_next = rx_shift;
                        we_next = wel_reg && !addr_blocked;
                        // Dropped byte still steps the address
                        if (!(wel_reg && !addr_blocked)) begin
                            addr_next = addr_reg + 18'h1;
                        end
                    end
                    spinv_pkg::ST_WSR: begin
                        if (wel_reg && !status_locked) begin
                            bp_next = rx_shift[spinv_pkg::SR_BP_LSB +: 2];
                            ppe_next = rx_shift[spinv_pkg::SR_PPE_BIT];
                        end
                        state_next = spinv_pkg::ST_IGNORE;
                    end
                    spinv_pkg::ST_ID: begin
                        id_idx_next = id_idx_reg + 2'h1;
                    end
                    default: begin
                        state_next = state_reg;
                    end
                endcase
            end
            if (pin.sck_fall && out_phase) begin
                so_oe_next = 1'b1;
                if (bit_cnt_reg == 3'h0) begin
                    so_next = out_byte[7];
                    tx_next = {out_byte[6:0], 1'b0};
                end else begin
                    so_next = tx_reg[7];
                    tx_next = {tx_reg[6:0], 1'b0};
                end
            end
        end
    end

    // =========================================================
    // Registers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_reg <= spinv_pkg::ST_CMD;
            bit_cnt_reg <= 3'h0;
            rx_reg <= 8'h00;
            cmd_reg <= 8'h00;
            addr_reg <= 18'h00000;
            addr_cnt_reg <= 2'h0;
            id_idx_reg <= 2'h0;
            tx_reg <= 8'h00;
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
            standby_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            rx_reg <= rx_next;
            cmd_reg <= cmd_next;
            addr_reg <= addr_next;
            addr_cnt_reg <= addr_cnt_next;
            id_idx_reg <= id_idx_next;
            tx_reg <= tx_next;
            so_reg <= so_next;
            so_oe_reg <= so_oe_next;
            standby_reg <= !pin.sel;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wel_reg <= spinv_pkg::WEL_RESET;
            ppe_reg <= spinv_pkg::PPE_RESET;
            bp_reg <= spinv_pkg::BP_RESET;
            clr_wel_reg <= 1'b0;
            we_reg <= 1'b0;
            wdata_reg <= 8'h00;
        end else begin
            wel_reg <= wel_next;
            ppe_reg <= ppe_next;
            bp_reg <= bp_next;
            clr_wel_reg <= clr_wel_next;
            we_reg <= we_next;
            wdata_reg <= wdata_next;
        end
    end

    assign mem.addr = addr_reg;
    assign mem.wdata = wdata_reg;
    assign mem.we = we_reg;
    assign so = so_reg;
    assign so_oe = so_oe_reg;
    assign standby = standby_reg;

    // =========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_write_byte;
        state_reg == spinv_pkg::ST_WDATA && byte_done && wel_reg && !addr_blocked;
    endsequence

    sequence s_commit;
        we_reg && mem.wdata == $past(rx_shift);
    endsequence

    chk_idle_output_off: assert property (!pin.sel |=> !so_oe_reg && standby_reg)
        else $error("output driven while deselected");

    chk_out_on_fall: assert property ($changed(so_reg) |-> $past(pin.sck_fall))
        else $error("serial output changed without falling clock");

    chk_oe_read_only: assert property (so_oe_reg && pin.sel |-> out_phase)
        else $error("output enabled outside read phase");

    chk_rx_on_rise: assert property ($changed(rx_reg) |-> $past(pin.sck_rise))
        else $error("input sampled without rising clock");

    chk_status_locked: assert property (status_locked |=> $stable(bp_reg) && $stable(ppe_reg))
        else $error("status written while protect pin active");

    chk_write_commit: assert property (s_write_byte |=> s_commit)
        else $error("received byte not committed next cycle");

    chk_select_command: assert property (pin.sel_start |=> state_reg == spinv_pkg::ST_CMD
        && bit_cnt_reg == 3'h0)
        else $error("selection did not restart command phase");

    chk_ignore_held: assert property (state_reg == spinv_pkg::ST_IGNORE && pin.sel
        && !pin.sel_start |=> state_reg == spinv_pkg::ST_IGNORE && !so_oe_reg)
        else $error("ignored command left its state");

    chk_pause_holds: assert property (pin.sel && !pin.sel_start && !pin.sck_rise
        |=> $stable(bit_cnt_reg) && $stable(rx_reg))
        else $error("transfer state moved during clock pause");

endmodule : spinv_port

`default_nettype wire

// ===== tb/spinv_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module spinv_master_model (
    input wire logic core_clk,
    input wire logic so_pin,
    output logic cs_n,
    output logic sck,
    output logic si
);
    logic mode3 = 1'b0;
    int stretch = 0;

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    task automatic ticks(input int n);
        repeat (n) @(negedge core_clk);
    endtask : ticks

    // ==========================================
    // Framing
    task automatic start(input logic m3);
        mode3 = m3;
        sck = m3;
        ticks(4);
        cs_n = 1'b0;
        ticks(4);
    endtask : start

    task automatic stop();
        sck = mode3;
        ticks(4);
        cs_n = 1'b1;
        // Released line no longer shows its last level
        si = ~si;
        ticks(4);
    endtask : stop

    // ==========================================
    // One byte each way, half period of 4 core cycles
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = tx[i];
            ticks(4);
            sck = 1'b1;
            ticks(4 + stretch);
            rx[i] = so_pin;
        end
    endtask : xfer

endmodule : spinv_master_model

`default_nettype wire

// ===== tb/test_spi_serial_nvram_slave_port.sv
`timescale 1ns/1ps
`default_nettype none

module test_spi_serial_nvram_slave_port;
    // Arbitrary identification value
    localparam logic [31:0] ID = 32'h3c_a7_02_01;
    logic core_clk;
    logic reset;
    logic wp_n;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic standby;
    wire logic so_pin;
    logic oe_seen;
    logic [7:0] rx;
    int fail_count = 0;
    int checks_done = 0;

    // Undriven pin shows the inverse of so, never its last driven level
    assign so_pin = so_oe ? so : ~so;

    spinv_port #(.ID_VALUE(ID)) u_dut (
        .core_clk(core_clk),
        .reset(reset),
        .cs_n(cs_n),
        .sck(sck),
        .si(si),
        .wp_n(wp_n),
        .so(so),
        .so_oe(so_oe),
        .standby(standby)
    );

    spinv_master_model u_master (
        .core_clk(core_clk),
        .so_pin(so_pin),
        .cs_n(cs_n),
        .sck(sck),
        .si(si)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (so_oe === 1'b1) oe_seen = 1'b1;
    end

    // ==========================================
    // Checking and closing
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        if (fail_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // ==========================================
    // Access tasks
    task automatic cmd(input logic [7:0] op);
        u_master.start(1'b0);
        u_master.xfer(op, rx);
        u_master.stop();
    endtask : cmd

    task automatic send_addr(input logic [23:0] a);
        u_master.xfer(a[23:16], rx);
        u_master.xfer(a[15:8], rx);
        u_master.xfer(a[7:0], rx);
    endtask : send_addr

    task automatic wr_mem(input logic [23:0] a, input logic [7:0] d);
        cmd(spinv_pkg::OP_WRITE_ENABLE);
        u_master.start(1'b0);
        u_master.xfer(spinv_pkg::OP_WRITE, rx);
        send_addr(a);
        u_master.xfer(d, rx);
        u_master.stop();
    endtask : wr_mem

    task automatic rd_mem(input logic m3, input logic fast, input logic [23:0] a,
                          input logic [7:0] exp);
        u_master.start(m3);
        u_master.xfer(fast ? spinv_pkg::OP_FAST_READ : spinv_pkg::OP_READ, rx);
        send_addr(a);
        if (fast) u_master.xfer(8'h00, rx);
        u_master.xfer(8'h00, rx);
        u_master.stop();
        chk(rx, exp);
    endtask : rd_mem

    task automatic wr_status(input logic [7:0] v);
        cmd(spinv_pkg::OP_WRITE_ENABLE);
        u_master.start(1'b0);
        u_master.xfer(spinv_pkg::OP_WRITE_STATUS, rx);
        u_master.xfer(v, rx);
        u_master.stop();
    endtask : wr_status

    task automatic rd_status(input logic [7:0] exp);
        u_master.start(1'b0);
        u_master.xfer(spinv_pkg::OP_READ_STATUS, rx);
        u_master.xfer(8'h00, rx);
        chk(rx, exp);
        u_master.xfer(8'h00, rx);
        chk(rx, exp);
        u_master.stop();
    endtask : rd_status

    // ==========================================
    // Tests
    initial begin
        reset = 1'b1;
        wp_n = 1'b1;
        oe_seen = 1'b0;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        chk({7'h0, standby}, 8'h01);
        u_master.xfer(spinv_pkg::OP_WRITE_ENABLE, rx);
        u_master.stop();
        chk({7'h0, standby}, 8'h01);
        chk({7'h0, oe_seen}, 8'h00);
        rd_status(8'h00);
        cmd(spinv_pkg::OP_WRITE_ENABLE);
        rd_status(8'h02);
        cmd(spinv_pkg::OP_WRITE_DISABLE);
        rd_status(8'h00);
        oe_seen = 1'b0;
        cmd(spinv_pkg::OP_WRITE_ENABLE);
        u_master.start(1'b0);
        u_master.xfer(spinv_pkg::OP_WRITE, rx);
        send_addr(24'hff_ff_ff);
        u_master.xfer(8'ha5, rx);
        u_master.xfer(8'h3c, rx);
        u_master.stop();
        chk({7'h0, oe_seen}, 8'h00);
        rd_mem(1'b1, 1'b0, 24'h03_ff_ff, 8'ha5);
        rd_mem(1'b0, 1'b1, 24'h00_00_00, 8'h3c);
        chk({7'h0, oe_seen}, 8'h01);
        cmd(spinv_pkg::OP_WRITE_ENABLE);
        cmd(spinv_pkg::OP_WRITE_DISABLE);
        u_master.start(1'b1);
        u_master.xfer(spinv_pkg::OP_WRITE, rx);
        send_addr(24'h00_00_00);
        u_master.xfer(8'h55, rx);
        u_master.stop();
        rd_mem(1'b0, 1'b0, 24'h00_00_00, 8'h3c);
        u_master.stretch = 100;
        rd_mem(1'b0, 1'b0, 24'h03_ff_ff, 8'ha5);
        u_master.stretch = 0;
        for (int k = 1; k < 4; k++) wr_mem({6'h0, k[1:0], 16'h0}, 8'h00);
        // Descending, so a blocked place still holds its zero
        for (int bp = 3; bp > 0; bp--) begin
            wr_status({4'h0, bp[1:0], 2'h0});
            rd_status({4'h0, bp[1:0], 2'h0});
            for (int k = 1; k < 4; k++) wr_mem({6'h0, k[1:0], 16'h0}, 8'he0 | 8'(bp));
            for (int k = 1; k < 4; k++) begin
                rd_mem(1'b0, 1'b0, {6'h0, k[1:0], 16'h0}, (k >= 4 - bp) ? 8'h00 : 8'he0 | 8'(bp));
            end
        end
        // Blocked byte at the top, next byte wraps into open space
        cmd(spinv_pkg::OP_WRITE_ENABLE);
        u_master.start(1'b0);
        u_master.xfer(spinv_pkg::OP_WRITE, rx);
        send_addr(24'h03_ff_ff);
        u_master.xfer(8'h11, rx);
        u_master.xfer(8'h22, rx);
        u_master.stop();
        rd_mem(1'b0, 1'b0, 24'h00_00_00, 8'h22);
        rd_mem(1'b0, 1'b0, 24'h03_ff_ff, 8'ha5);
        wr_status(8'h80);
        rd_status(8'h80);
        wp_n = 1'b0;
        wr_status(8'h8c);
        rd_status(8'h80);
        wp_n = 1'b1;
        wr_status(8'h00);
        rd_status(8'h00);
        u_master.start(1'b0);
        u_master.xfer(spinv_pkg::OP_READ_ID, rx);
        chk({7'h0, standby}, 8'h00);
        for (int i = 0; i < 5; i++) begin
            u_master.xfer(8'h00, rx);
            chk(rx, 8'(ID >> (24 - 8 * (i % 4))));
        end
        u_master.stop();
        oe_seen = 1'b0;
        u_master.start(1'b1);
        u_master.xfer(8'hb9, rx);
        u_master.xfer(spinv_pkg::OP_READ_STATUS, rx);
        u_master.xfer(8'h00, rx);
        u_master.stop();
        chk({7'h0, oe_seen}, 8'h00);
        u_master.start(1'b0);
        u_master.xfer(spinv_pkg::OP_WRITE_ENABLE, rx);
        u_master.xfer(spinv_pkg::OP_READ_STATUS, rx);
        u_master.xfer(8'h00, rx);
        u_master.stop();
        chk({7'h0, oe_seen}, 8'h00);
        rd_status(8'h02);
        // Mid-run reset: status is volatile, array keeps its bytes
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        chk({7'h0, standby}, 8'h01);
        rd_status(8'h00);
        rd_mem(1'b0, 1'b0, 24'h03_ff_ff, 8'ha5);
        close_out();
    end

    initial begin
        #3ms;
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        close_out();
    end

endmodule : test_spi_serial_nvram_slave_port

`default_nettype wire
